/* core/led_fault_irq_enable_ctrl.sv */
// led fault interrupt enable field: state, read code and interrupt gate
// assumes a register bank on clk_sys supplies a one-cycle write strobe with data
// assumes the fault detector runs on clk_sys too, so its event needs no synchroniser
// assumes interrupt status, clearing and the pin sit downstream of ledFaultIrq
`timescale 1ns/1ns
`default_nettype none

module led_fault_irq_enable_ctrl
  import led_fault_irq_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       wrStrobe,
  input  wire logic [1:0] wrData,
  input  wire logic       ledFaultEvent,
  output var  logic [1:0] rdData,
  output var  logic       ledFaultIrq,
  output var  logic       ledFaultIrqEnable
);

  // ----------------------------------------
  // notes for users of this block
  // ----------------------------------------
  // no sticky status here: a fault must stand across a clock edge to be seen
  // codes 0h and 2h are dropped silently, with no error flag
  // a fault and a write in one cycle: the request follows the new state
  // the read code lags the write by one cycle, as any registered field does

  // ----------------------------------------
  // code helpers
  // ----------------------------------------
  // read code for a state; reset and update share it so they cannot drift
  function automatic logic [1:0] read_code(input logic en);
    logic [1:0] code;
    if (en) begin
      code = RdEnabled;
    end else begin
      code = RdDisabled;
    end
    return code;
  endfunction

  // true only for a strobed write carrying exactly this command code
  function automatic logic is_command(input logic strobe, input logic [1:0] data, input logic [1:0] code);
    logic hit;
    hit = strobe && (data == code);
    return hit;
  endfunction

  // ----------------------------------------
  // internal nets
  // ----------------------------------------
  // one next value per register, all decoded here
  wire logic       wrDis;       // strobed disable command
  wire logic       wrEna;       // strobed enable command
  wire logic       next_en;     // state after this edge
  wire logic [1:0] next_rdData; // read code after this edge
  wire logic       next_irq;    // request after this edge

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // two distinct codes so a stray write of the read value is harmless
  assign wrDis = is_command(wrStrobe, wrData, WrDisable);
  assign wrEna = is_command(wrStrobe, wrData, WrEnable);

  // the codes differ in bit 1, so at most one decodes; other codes hold
  assign next_en = wrEna ? 1'b1 : (wrDis ? 1'b0 : ledFaultIrqEnable);

  // ----------------------------------------
  // read code and request gate
  // ----------------------------------------
  // both use the state after this edge, so a write and a fault may share a cycle
  assign next_rdData = read_code(next_en);
  assign next_irq    = ledFaultEvent && next_en;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // enable state, the only real storage of the field
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ledFaultIrqEnable <= EnReset;
    end else begin
      ledFaultIrqEnable <= next_en;
    end
  end

  // read code and gated request, registered so the bank sees clean levels
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData      <= read_code(EnReset);
      ledFaultIrq <= 1'b0;
    end else begin
      rdData      <= next_rdData;
      ledFaultIrq <= next_irq;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // one clock domain, nothing checked while reset is held
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // reset state
  a_reset_value_enabled: assert property (
    $fell(rst)
    |-> rdData == RdEnabled && ledFaultIrqEnable
  ) else $error("field not enabled after reset");

  a_reset_irq_quiet: assert property (
    $fell(rst)
    |-> !ledFaultIrq
  ) else $error("request pending right after reset");

  // read codes follow the state
  a_read_disabled_code: assert property (
    !ledFaultIrqEnable
    |-> rdData == RdDisabled
  ) else $error("disabled state reads wrong code");

  a_read_enabled_code: assert property (
    ledFaultIrqEnable
    |-> rdData == RdEnabled
  ) else $error("enabled state reads wrong code");

  a_read_code_legal: assert property (
    rdData == RdDisabled || rdData == RdEnabled
  ) else $error("read code outside the two legal values");

  // disable command
  a_write_disable_takes: assert property (
    wrStrobe && wrData == WrDisable
    |=> rdData == RdDisabled
  ) else $error("write 1h did not disable");

  a_disable_state_low: assert property (
    wrStrobe && wrData == WrDisable
    |=> !ledFaultIrqEnable
  ) else $error("write 1h left the state enabled");

  a_enable_fall_cause: assert property (
    $fell(ledFaultIrqEnable)
    |-> $past(wrDis)
  ) else $error("state disabled without disable write");

  // enable command
  a_write_enable_takes: assert property (
    wrStrobe && wrData == WrEnable
    |=> rdData == RdEnabled
  ) else $error("write 3h did not enable");

  a_enable_state_high: assert property (
    wrStrobe && wrData == WrEnable
    |=> ledFaultIrqEnable
  ) else $error("write 3h left the state disabled");

  a_enable_rise_cause: assert property (
    $rose(ledFaultIrqEnable)
    |-> $past(wrEna) || $past(rst)
  ) else $error("state enabled without enable write or reset");

  // ignored codes and idle cycles
  a_other_write_holds: assert property (
    wrStrobe && !wrData[0]
    |=> $stable(ledFaultIrqEnable)
  ) else $error("write 0h or 2h changed state");

  a_ignored_code_holds: assert property (
    wrStrobe && !wrData[0]
    |=> $stable(rdData)
  ) else $error("write 0h or 2h changed the read code");

  a_idle_state_holds: assert property (
    !wrStrobe
    |=> $stable(ledFaultIrqEnable)
  ) else $error("state changed without a write");

  a_idle_code_holds: assert property (
    !wrStrobe
    |=> $stable(rdData)
  ) else $error("read code changed without a write");

  // request gate
  a_irq_gated_enable: assert property (
    ledFaultIrq
    |-> ledFaultIrqEnable && $past(ledFaultEvent)
  ) else $error("request without enable or fault");

  a_irq_passes_enabled: assert property (
    ledFaultEvent && next_en
    |=> ledFaultIrq
  ) else $error("enabled fault gave no request");

  a_disabled_blocks_irq: assert property (
    ledFaultEvent && !next_en
    |=> !ledFaultIrq
  ) else $error("fault passed while disabled");

  a_no_fault_quiet: assert property (
    !ledFaultEvent
    |=> !ledFaultIrq
  ) else $error("request without a fault");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  // main scenarios the random bench should reach
  c_disable_then_fault: cover property (
    wrDis ##1 ledFaultEvent ##1 !ledFaultIrq);
  c_reenable_fault: cover property (
    wrDis ##[1:4] wrEna ##1 ledFaultEvent ##1 ledFaultIrq);
  c_ignored_write: cover property (
    wrStrobe && wrData == 2'h0 && ledFaultIrqEnable);
  c_fault_while_enabled: cover property (
    (ledFaultIrqEnable && ledFaultEvent) ##1 ledFaultIrq);
  c_back_to_back_writes: cover property (
    wrDis ##1 wrEna ##1 ledFaultIrqEnable);

endmodule

`default_nettype wire

/* core/led_fault_irq_pkg.sv */
// constants for the led fault interrupt enable field
// assumes the register bank decodes the address and hands us field strobes
package led_fault_irq_pkg;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int unsigned FieldLsb   = 0;
  localparam int unsigned FieldWidth = 2;

  // ----------------------------------------
  // read codes, write codes, reset value
  // ----------------------------------------
  localparam logic [1:0] RdDisabled = 2'h0;
  localparam logic [1:0] RdEnabled  = 2'h2;
  localparam logic [1:0] WrDisable  = 2'h1;
  localparam logic [1:0] WrEnable   = 2'h3;
  localparam logic       EnReset    = 1'h1;

endpackage

/* verification/tb.sv */
// bench for the led fault interrupt enable field
// assumes the design carries its own assertions; the bench drives all inputs
`timescale 1ns/1ns
`default_nettype none
module tb;
  import led_fault_irq_pkg::*;
  // ----------------------------------------
  // design, clock and model state
  // ----------------------------------------
  logic       clk_sys, rst, wrStrobe, ledFaultEvent, ledFaultIrq, ledFaultIrqEnable;
  logic [1:0] wrData, rdData;
  int         numErrors, checksDone, en, irq;
  led_fault_irq_enable_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .wrStrobe(wrStrobe), .wrData(wrData),
    .ledFaultEvent(ledFaultEvent), .rdData(rdData), .ledFaultIrq(ledFaultIrq), .ledFaultIrqEnable(ledFaultIrqEnable));
  // 250 mhz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // compare, close, one modelled cycle
  // ----------------------------------------
  task automatic check(input string what, input logic [1:0] seen, input logic [1:0] want);
    checksDone++;
    if (seen !== want) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // drive at the falling edge, compare one falling edge later; codes 0h and 2h must not move the state
  task automatic step(input logic r, input logic w, input logic [1:0] d, input logic f);
    rst = r;
    wrStrobe = w;
    wrData = d;
    ledFaultEvent = f;
    @(negedge clk_sys);
    if (r) en = 1;
    else if (w && d == WrDisable) en = 0;
    else if (w && d == WrEnable) en = 1;
    irq = !r && f && en;
    check("rdData", rdData, en ? RdEnabled : RdDisabled);
    check("enable", {1'b0, ledFaultIrqEnable}, en[1:0]);
    check("irq", {1'b0, ledFaultIrq}, irq[1:0]);
  endtask
  // reset over 16 rising edges (one before the first step), a fault present on the last 15,
  // then 600 random cycles: writes of every code on about half, faults, rare resets
  initial begin
    {rst, wrStrobe, wrData, ledFaultEvent} = 5'h10;
    void'($urandom(29));
    @(negedge clk_sys);
    repeat (15) step(1'b1, 1'b0, 2'h0, 1'b1);
    $display("reset test done");
    repeat (600) step($urandom_range(0, 49) == 0, 1'($urandom), 2'($urandom), 1'($urandom));
    $display("random test done");
    end_of_test();
  end
endmodule
`default_nettype wire
